// File: hw/vrh_top.v
// Voltage reference hold supervisor with AXI4-Lite register slave
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`include "vrh_defines.vh"
module vrh_top
#(
  parameter NCH         = 6,
  parameter TICK_CYCLES = `VRH_HOLD_STEP_NS / `VRH_CLK_PERIOD_NS
)
(
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output reg              s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output reg              s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output reg              s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready,
  input  wire             prog_cycle_tick,
  input  wire             hold_block_pin,
  input  wire [NCH*16-1:0] volt_mag,
  input  wire [NCH*16-1:0] volt_ang,
  input  wire [47:0]      phase_cur_mag,
  input  wire [15:0]      third_phase_current_freq,
  output reg  [15:0]      ref_amp_ff,
  output reg  [NCH*16-1:0] ref_ang_ff,
  output reg              ref_valid_ff,
  output reg              voltage_reference_hold_on_ff,
  output reg  [15:0]      sample_freq_ff,
  output reg              current_frequency_follow_on_ff,
  output reg  [11:0]      event_pulse_ff
);

  localparam ST_IDLE    = 2'd0;
  localparam ST_ENGAGED = 2'd1;
  localparam ST_EXPIRED = 2'd2;

  localparam [1:0] RESP_OKAY   = 2'b00;
  localparam [1:0] RESP_DECERR = 2'b11;

  reg  [3:0]       ctrl_ff;
  reg  [15:0]      vthr_ff;
  reg  [15:0]      ipick_ff;
  reg  [15:0]      hold_ff;
  reg  [NCH-1:0]   used_ff;
  reg  [11:0]      ev_sticky_ff;
  reg  [1:0]       state_ff;
  reg  [1:0]       nxt_state;
  reg  [31:0]      presc_ff;
  reg  [15:0]      steps_ff;
  reg  [NCH*16-1:0] ang_prev_ff;
  reg              blocked_ff;
  reg              vlow_ff;
  reg              ihigh_ff;
  reg              track_ff;
  reg              en_prev_ff;
  reg  [7:0]       aw_addr_ff;
  reg  [31:0]      w_data_ff;
  reg  [3:0]       w_strb_ff;
  reg  [11:0]      ev_now;
  reg  [31:0]      rd_val;
  reg              rd_hit;
  reg              vlow;
  reg              any_used;
  wire             block_sync;
  wire             ihigh;
  wire             engage_ok;
  wire             track;
  wire             wr_go;
  wire [15:0]      wr_lo;
  wire [31:0]      tick_last;
  integer          i;

  vrh_sync u_block_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (hold_block_pin),
    .dout    (block_sync)
  );

  always @*
  begin
    vlow     = 1'b1;
    any_used = 1'b0;
    for (i = 0; i < NCH; i = i + 1)
    begin
      if (used_ff[i])
      begin
        any_used = 1'b1;
        if (volt_mag[i*16 +: 16] >= vthr_ff)
          vlow = 1'b0;
      end
    end
    vlow = vlow & any_used;
  end

  assign ihigh = (phase_cur_mag[15:0] > ipick_ff) | (phase_cur_mag[31:16] > ipick_ff)
               | (phase_cur_mag[47:32] > ipick_ff);

  assign engage_ok = ctrl_ff[`VRH_CTRL_ENABLE] & vlow & ~blocked_ff
                   & (ihigh | ~ctrl_ff[`VRH_CTRL_CURCOND]);

  assign track = ctrl_ff[`VRH_CTRL_FOLLOW] & vlow;

  assign tick_last = TICK_CYCLES - 1;

  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (engage_ok)
          nxt_state = ST_ENGAGED;
      ST_ENGAGED:
        if (!engage_ok)
          nxt_state = ST_IDLE;
        else if (presc_ff == tick_last && steps_ff + 16'h0001 >= hold_ff)
          nxt_state = ST_EXPIRED;
      ST_EXPIRED:
        if (!engage_ok)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always @*
  begin
    ev_now = 12'h000;
    ev_now[`VRH_EV_ENABLED]   = ctrl_ff[`VRH_CTRL_ENABLE] & ~en_prev_ff;
    ev_now[`VRH_EV_DISABLED]  = ~ctrl_ff[`VRH_CTRL_ENABLE] & en_prev_ff;
    ev_now[`VRH_EV_BLOCK_ON]  = prog_cycle_tick & block_sync & ~blocked_ff;
    ev_now[`VRH_EV_BLOCK_OFF] = prog_cycle_tick & ~block_sync & blocked_ff;
    ev_now[`VRH_EV_VLOW_ON]   = vlow & ~vlow_ff;
    ev_now[`VRH_EV_VLOW_OFF]  = ~vlow & vlow_ff;
    ev_now[`VRH_EV_IHIGH_ON]  = ihigh & ~ihigh_ff;
    ev_now[`VRH_EV_IHIGH_OFF] = ~ihigh & ihigh_ff;
    ev_now[`VRH_EV_TRACK_ON]  = track & ~track_ff;
    ev_now[`VRH_EV_TRACK_OFF] = ~track & track_ff;
    ev_now[`VRH_EV_USE_ON]    = (nxt_state == ST_ENGAGED) & (state_ff != ST_ENGAGED);
    ev_now[`VRH_EV_USE_OFF]   = (nxt_state != ST_ENGAGED) & (state_ff == ST_ENGAGED);
  end

  // Supervisor state, timer, outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff                       <= ST_IDLE;
      presc_ff                       <= 32'h00000000;
      steps_ff                       <= 16'h0000;
      ang_prev_ff                    <= {NCH*16{1'b0}};
      blocked_ff                     <= 1'b0;
      vlow_ff                        <= 1'b0;
      ihigh_ff                       <= 1'b0;
      track_ff                       <= 1'b0;
      en_prev_ff                     <= 1'b0;
      ref_amp_ff                     <= 16'h0000;
      ref_ang_ff                     <= {NCH*16{1'b0}};
      ref_valid_ff                   <= 1'b0;
      voltage_reference_hold_on_ff   <= 1'b0;
      sample_freq_ff                 <= `VRH_FREQ_50;
      current_frequency_follow_on_ff <= 1'b0;
      event_pulse_ff                 <= 12'h000;
    end
    else
    begin
      state_ff   <= nxt_state;
      vlow_ff    <= vlow;
      ihigh_ff   <= ihigh;
      track_ff   <= track;
      en_prev_ff <= ctrl_ff[`VRH_CTRL_ENABLE];
      // block taken once per program cycle
      if (prog_cycle_tick)
        blocked_ff <= block_sync;
      if (nxt_state == ST_ENGAGED && state_ff == ST_ENGAGED)
      begin
        if (presc_ff == tick_last)
        begin
          presc_ff <= 32'h00000000;
          steps_ff <= steps_ff + 16'h0001;
        end
        else
          presc_ff <= presc_ff + 32'h00000001;
      end
      else
      begin
        presc_ff <= 32'h00000000;
        steps_ff <= 16'h0000;
      end
      if (!vlow && state_ff == ST_IDLE)
        ang_prev_ff <= volt_ang;
      if (nxt_state == ST_ENGAGED && state_ff != ST_ENGAGED)
        ref_ang_ff <= ang_prev_ff;
      else if (nxt_state != ST_ENGAGED)
        ref_ang_ff <= volt_ang;
      ref_amp_ff <= (nxt_state == ST_ENGAGED) ? vthr_ff : 16'h0000;
      ref_valid_ff <= (nxt_state == ST_ENGAGED);
      voltage_reference_hold_on_ff <= (nxt_state == ST_ENGAGED);
      if (track)
        sample_freq_ff <= third_phase_current_freq;
      else
        sample_freq_ff <= ctrl_ff[`VRH_CTRL_FREQ60] ? `VRH_FREQ_60 : `VRH_FREQ_50;
      current_frequency_follow_on_ff <= track;
      event_pulse_ff                 <= ev_now;
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_lo = {(w_strb_ff[1] ? w_data_ff[15:8] : 8'h00), (w_strb_ff[0] ? w_data_ff[7:0] : 8'h00)};

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr_ff    <= 8'h00;
      w_data_ff     <= 32'h00000000;
      w_strb_ff     <= 4'h0;
      ctrl_ff       <= `VRH_RST_CTRL;
      vthr_ff       <= `VRH_RST_VTHR;
      ipick_ff      <= `VRH_RST_IPICK;
      hold_ff       <= `VRH_RST_HOLD;
      used_ff       <= `VRH_RST_USED;
      ev_sticky_ff  <= 12'h000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_ff    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_ff    <= s_axi_wdata;
        w_strb_ff    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      // Hardware set wins over software clear
      ev_sticky_ff <= ev_sticky_ff | ev_now;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        case ({2'b00, aw_addr_ff[7:2]})
          `VRH_OFS_CTRL >> 2:
            if (w_strb_ff[0])
              ctrl_ff <= w_data_ff[3:0];
          `VRH_OFS_VTHR >> 2:
            vthr_ff <= (wr_lo < `VRH_VTHR_MIN) ? `VRH_VTHR_MIN :
                       (wr_lo > `VRH_VTHR_MAX) ? `VRH_VTHR_MAX : wr_lo;
          `VRH_OFS_IPICK >> 2:
            ipick_ff <= wr_lo;
          `VRH_OFS_HOLD >> 2:
            hold_ff <= (wr_lo < `VRH_HOLD_MIN) ? `VRH_HOLD_MIN :
                       (wr_lo > `VRH_HOLD_MAX) ? `VRH_HOLD_MAX : wr_lo;
          `VRH_OFS_USED >> 2:
            if (w_strb_ff[0])
              used_ff <= w_data_ff[NCH-1:0];
          `VRH_OFS_EVENTS >> 2:
            ev_sticky_ff <= (ev_sticky_ff & ~wr_lo[11:0]) | ev_now;
          `VRH_OFS_STATUS >> 2, `VRH_OFS_REFAMP >> 2:
            s_axi_bresp <= RESP_OKAY;
          default:
            s_axi_bresp <= RESP_DECERR;
        endcase
      end
    end
  end

  // Read decode
  always @*
  begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    case ({2'b00, s_axi_araddr[7:2]})
      `VRH_OFS_CTRL >> 2:   rd_val = {28'h0000000, ctrl_ff};
      `VRH_OFS_VTHR >> 2:   rd_val = {16'h0000, vthr_ff};
      `VRH_OFS_IPICK >> 2:  rd_val = {16'h0000, ipick_ff};
      `VRH_OFS_HOLD >> 2:   rd_val = {16'h0000, hold_ff};
      `VRH_OFS_USED >> 2:   rd_val = {{(32-NCH){1'b0}}, used_ff};
      `VRH_OFS_STATUS >> 2:
        rd_val = {26'h0000000, state_ff == ST_EXPIRED, blocked_ff, track_ff,
                  ihigh_ff, vlow_ff, state_ff == ST_ENGAGED};
      `VRH_OFS_EVENTS >> 2: rd_val = {20'h00000, ev_sticky_ff};
      `VRH_OFS_REFAMP >> 2: rd_val = {16'h0000, ref_amp_ff};
      default:              rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// File: hw/vrh_defines.vh
// Constants and register map of the voltage reference hold block
`ifndef VRH_DEFINES_VH
`define VRH_DEFINES_VH

`define VRH_OFS_CTRL        8'h00
`define VRH_OFS_VTHR        8'h04
`define VRH_OFS_IPICK       8'h08
`define VRH_OFS_HOLD        8'h0C
`define VRH_OFS_USED        8'h10
`define VRH_OFS_STATUS      8'h14
`define VRH_OFS_EVENTS      8'h18
`define VRH_OFS_REFAMP      8'h1C

`define VRH_CTRL_ENABLE     0
`define VRH_CTRL_CURCOND    1
`define VRH_CTRL_FOLLOW     2
`define VRH_CTRL_FREQ60     3

`define VRH_RST_CTRL        4'h0
`define VRH_RST_VTHR        16'h07D0
`define VRH_RST_IPICK       16'h0064
`define VRH_RST_HOLD        16'h0064
`define VRH_RST_USED        6'h38

// Threshold in 0.01 V, hold in 0.01 s
`define VRH_VTHR_MIN        16'h00C8
`define VRH_VTHR_MAX        16'h1388
`define VRH_HOLD_MIN        16'h0002
`define VRH_HOLD_MAX        16'h1388

// Sampling frequency in 0.01 Hz
`define VRH_FREQ_50         16'h1388
`define VRH_FREQ_60         16'h1770

`define VRH_CLK_PERIOD_NS   10
`define VRH_HOLD_STEP_NS    10000000

`define VRH_EV_ENABLED      0
`define VRH_EV_DISABLED     1
`define VRH_EV_VLOW_ON      2
`define VRH_EV_VLOW_OFF     3
`define VRH_EV_IHIGH_ON     4
`define VRH_EV_IHIGH_OFF    5
`define VRH_EV_TRACK_ON     6
`define VRH_EV_TRACK_OFF    7
`define VRH_EV_USE_ON       8
`define VRH_EV_USE_OFF      9
`define VRH_EV_BLOCK_ON     10
`define VRH_EV_BLOCK_OFF    11
`define VRH_EV_COUNT        12

`endif

// File: hw/vrh_sync.v
// Three-stage synchroniser that passes a level once stages two and three agree
module vrh_sync
(
  input  wire aclk,
  input  wire aresetn,
  input  wire din,
  output reg  dout
);

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      dout  <= 1'b0;
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
        dout <= s3_ff;
    end
  end

endmodule

// File: tb/vrh_dir_stage.sv
// Directional stage model that consumes the held voltage reference
module vrh_dir_stage
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ref_valid,
  input  wire logic [15:0] ref_amp,
  output logic             dir_mode_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // Non-directional once no reference is offered
  always @(posedge aclk)
    if (!aresetn)
      dir_mode_ff <= 1'b0;
    else
      dir_mode_ff <= ref_valid && ref_amp != 16'h0000;
endmodule

// File: tb/vrh_top_properties.sv
// Output assertions for the voltage reference hold block
module vrh_chk
#(
  parameter NCH = 6
)
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [15:0]       ref_amp_ff,
  input wire logic [NCH*16-1:0] ref_ang_ff,
  input wire logic              ref_valid_ff,
  input wire logic              voltage_reference_hold_on_ff,
  input wire logic [15:0]       sample_freq_ff,
  input wire logic              current_frequency_follow_on_ff,
  input wire logic [11:0]       event_pulse_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  inuse_valid_a: assert property (
    voltage_reference_hold_on_ff == ref_valid_ff) else $error("in-use and valid differ");
  amp_range_a: assert property (
    ref_valid_ff |-> ref_amp_ff >= 16'h00C8 && ref_amp_ff <= 16'h1388) else $error("amplitude off");
  amp_idle_a: assert property (
    !ref_valid_ff |-> ref_amp_ff == 16'h0000) else $error("amplitude without reference");
  ang_hold_a: assert property (
    ref_valid_ff && $past(ref_valid_ff) |-> $stable(ref_ang_ff)) else $error("held angle moved");
  engage_ev_a: assert property (
    $rose(voltage_reference_hold_on_ff) |-> event_pulse_ff[8]) else $error("no engage event");
  release_ev_a: assert property (
    $fell(voltage_reference_hold_on_ff) |-> event_pulse_ff[9]) else $error("no release event");
  // A cycle of slack after tracking stops
  freq_fixed_a: assert property (
    !current_frequency_follow_on_ff && !$past(current_frequency_follow_on_ff)
    |-> sample_freq_ff inside {16'h1388, 16'h1770}) else $error("not a fixed frequency");
  track_ev_a: assert property (
    $rose(current_frequency_follow_on_ff) |-> ##[0:1] event_pulse_ff[6]) else $error("no track event");
  pulse_one_a: assert property (
    event_pulse_ff[8] |=> !event_pulse_ff[8]) else $error("event longer than a cycle");
endmodule

bind vrh_top vrh_chk #(.NCH(NCH)) u_chk (.*);

// File: tb/vrh_top_bench.sv
// Self-checking bench for the voltage reference hold block
module vrh_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam TK = 4;
  typedef struct {logic [3:0] ctrl; int hi; logic [15:0] vm, cur; logic on; logic [15:0] fq;} vrh_row_t;
  logic        aclk = '0, aresetn = '0, prog_cycle_tick = '0, hold_block_pin = '0;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [95:0] volt_mag = '0, volt_ang = '0;
  logic [47:0] phase_cur_mag = '0;
  logic [15:0] third_phase_current_freq = 16'h11F8;
  logic [1:0]  tc_ff = '0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dir_mode_ff;
  wire         ref_valid_ff, voltage_reference_hold_on_ff, current_frequency_follow_on_ff;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [15:0]  ref_amp_ff, sample_freq_ff;
  wire [95:0]  ref_ang_ff;
  wire [11:0]  event_pulse_ff;
  int          n_errors = 0, checked = 0;
  vrh_row_t    rows [9] = '{
    '{4'h0, 7, 16'h0100, 16'h0000, 1'b0, 16'h1388},
    '{4'h1, 7, 16'h07D0, 16'h0000, 1'b0, 16'h1388},
    '{4'h1, 7, 16'h07CF, 16'h0000, 1'b1, 16'h1388},
    '{4'h1, 5, 16'h0100, 16'h0000, 1'b0, 16'h1388},
    '{4'h1, 0, 16'h0100, 16'h0000, 1'b1, 16'h1388},
    '{4'h3, 7, 16'h0100, 16'h0064, 1'b0, 16'h1388},
    '{4'h3, 7, 16'h0100, 16'h0065, 1'b1, 16'h1388},
    '{4'h5, 7, 16'h0100, 16'h0000, 1'b1, 16'h11F8},
    '{4'h9, 7, 16'h07D0, 16'h0000, 1'b0, 16'h1770}};

  vrh_top #(.TICK_CYCLES(TK)) DUT (.*);
  vrh_dir_stage u_dir (.aclk, .aresetn, .ref_valid(ref_valid_ff), .ref_amp(ref_amp_ff), .dir_mode_ff);

  initial forever #5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    tc_ff <= tc_ff + 2'h1;
    prog_cycle_tick <= tc_ff == 2'h0;
  end

  task results;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [95:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tmo;
    n_errors++;
    $display("FAIL %0t bus timeout", $time);
    results;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
      if (s_axi_bvalid) break;
    end
    if (i == 40) tmo;
    s_axi_bready <= '0;
    chk(s_axi_bresp, er);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    for (i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= '0;
      if (s_axi_rvalid) break;
    end
    if (i == 40) tmo;
    s_axi_rready <= '0;
    chk(s_axi_rdata, ex);
    chk(s_axi_rresp, er);
  endtask
  task volts(input logic [15:0] v, input int n);
    volt_mag <= {6{v}};
    repeat (n) @(posedge aclk);
  endtask

  initial
  begin
    int i, j, n;
    repeat (6) @(posedge aclk);
    aresetn <= '1;
    rd(8'h00, 32'h0, 2'b00);
    rd(8'h04, 32'h07D0, 2'b00);
    rd(8'h08, 32'h0064, 2'b00);
    rd(8'h10, 32'h38, 2'b00);
    rd(8'h20, 32'h0, 2'b11);
    wr(8'h20, 32'h1, 2'b11);
    chk(sample_freq_ff, 16'h1388);
    // Below the minimum must clamp to two steps
    wr(8'h0C, 32'h1, 2'b00);
    rd(8'h0C, 32'h2, 2'b00);
    wr(8'h04, 32'h1, 2'b00);
    rd(8'h04, 32'h00C8, 2'b00);
    wr(8'h04, 32'h2000, 2'b00);
    rd(8'h04, 32'h1388, 2'b00);
    wr(8'h04, 32'h07D0, 2'b00);
    foreach (rows[k])
    begin
      volt_mag <= {6{16'h2710}};
      volt_ang <= {6{16'h1234}};
      wr(8'h00, rows[k].ctrl, 2'b00);
      repeat (2) @(posedge aclk);
      for (j = 0; j < 6; j++)
        volt_mag[j*16+:16] <= (j == rows[k].hi) ? 16'h2710 : rows[k].vm;
      volt_ang <= {6{16'h4321}};
      phase_cur_mag <= {16'h0000, rows[k].cur, 16'h0000};
      repeat (3) @(posedge aclk);
      chk(voltage_reference_hold_on_ff, rows[k].on);
      chk(ref_amp_ff, rows[k].on ? 16'h07D0 : 16'h0000);
      chk(ref_ang_ff, rows[k].on ? {6{16'h1234}} : {6{16'h4321}});
      chk(sample_freq_ff, rows[k].fq);
      phase_cur_mag <= '0;
    end
    volts(16'h2710, 3);
    wr(8'h00, 32'h1, 2'b00);
    volts(16'h0100, 3);
    volts(16'h2710, 3);
    chk(voltage_reference_hold_on_ff, 1'b0);
    volt_mag <= {6{16'h0100}};
    n = 0;
    for (i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (voltage_reference_hold_on_ff) n++;
    end
    chk(n, 2 * TK);
    chk(dir_mode_ff, 1'b0);
    volts(16'h2710, 3);
    volts(16'h0100, 3);
    chk(voltage_reference_hold_on_ff, 1'b1);
    volts(16'h2710, 3);
    hold_block_pin <= '1;
    volts(16'h2710, 12);
    volts(16'h0100, 4);
    chk(voltage_reference_hold_on_ff, 1'b0);
    rd(8'h14, 32'h12, 2'b00);
    hold_block_pin <= '0;
    for (i = 0; i < 20 && voltage_reference_hold_on_ff !== 1'b1; i++) @(posedge aclk);
    chk(voltage_reference_hold_on_ff, 1'b1);
    volts(16'h2710, 3);
    wr(8'h00, 32'h0, 2'b00);
    wr(8'h18, 32'hFFF, 2'b00);
    rd(8'h18, 32'h0, 2'b00);
    wr(8'h00, 32'h5, 2'b00);
    phase_cur_mag <= {3{16'h0200}};
    volts(16'h0100, 4);
    phase_cur_mag <= '0;
    volts(16'h2710, 4);
    hold_block_pin <= '1;
    volts(16'h2710, 12);
    hold_block_pin <= '0;
    volts(16'h2710, 12);
    wr(8'h00, 32'h0, 2'b00);
    rd(8'h18, 32'hFFF, 2'b00);
    results;
  end
endmodule
